// ===== rtl/comp_regs_pkg.sv
// Constants, types and carriers for the dual comparator register bank
package comp_regs_pkg;

	// ----------------------------------------
	// Bus and register map
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NUM_COMP = 2;
	localparam logic [7:0] IDX_COMP1_CONTROL = 8'h9A;
	localparam logic [7:0] IDX_COMP0_CONTROL = 8'h9B;
	localparam logic [7:0] IDX_COMP0_MODE = 8'h9D;
	localparam logic [ADDR_W-1:0] ADDR_COMP1_CONTROL = {2'h0, IDX_COMP1_CONTROL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_COMP0_CONTROL = {2'h0, IDX_COMP0_CONTROL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_COMP0_MODE = {2'h0, IDX_COMP0_MODE, 2'h0};

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTL_EN_BIT = 7;
	localparam int CTL_OUT_BIT = 6;
	localparam int CTL_RISE_BIT = 5;
	localparam int CTL_FALL_BIT = 4;
	localparam int CTL_PHYST_LSB = 2;
	localparam int CTL_NHYST_LSB = 0;
	localparam int MD_RSVD_BIT = 7;
	localparam int MD_RISE_IE_BIT = 5;
	localparam int MD_FALL_IE_BIT = 4;
	localparam int MD_SPEED_LSB = 0;
	localparam logic MD_RSVD_VAL = 1'h1;
	localparam logic [1:0] SPEED_RESET = 2'h2;

	// ----------------------------------------
	// Encodings and carriers
	// ----------------------------------------
	typedef enum logic [1:0] {HYST_OFF = 2'b00, HYST_5MV = 2'b01, HYST_10MV = 2'b10, HYST_20MV = 2'b11} hyst_e;
	typedef enum logic [1:0] {SPEED_M0 = 2'b00, SPEED_M1 = 2'b01, SPEED_M2 = 2'b10, SPEED_M3 = 2'b11} speed_e;
	typedef enum logic [1:0] {SEL_NONE = 2'b00, SEL_C0_CTL = 2'b01, SEL_C1_CTL = 2'b10, SEL_C0_MODE = 2'b11} reg_sel_e;

	typedef struct packed {
		logic enable;
		hyst_e pos_hyst;
		hyst_e neg_hyst;
	} comp_cfg_s;

	typedef struct packed {
		logic out_state;
		logic rise_flag;
		logic fall_flag;
	} comp_stat_s;

endpackage

// ===== rtl/comp_channel.sv
// One comparator channel: output synchroniser, edge detector and sticky flags
`timescale 1ns/1ps
`default_nettype none
module comp_channel
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic raw_out,
	input wire comp_regs_pkg::comp_cfg_s cfg,
	input wire logic flag_wr,
	input wire logic rise_wdata,
	input wire logic fall_wdata,
	output var comp_regs_pkg::comp_stat_s stat
);
	import comp_regs_pkg::*;

	logic sync1_q;
	logic sync2_q;
	logic out_q;
	logic prev_q;
	logic rise_q;
	logic fall_q;
	logic rise_evt;
	logic fall_evt;

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			sync1_q <= 1'h0;
			sync2_q <= 1'h0;
		end
		else
		begin
			sync1_q <= raw_out;
			sync2_q <= sync1_q;
		end
	end

	// Disabled comparator reads low, shutdown output is meaningless
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			out_q <= 1'h0;
			prev_q <= 1'h0;
		end
		else
		begin
			out_q <= cfg.enable & sync2_q;
			prev_q <= out_q;
		end
	end

	// ----------------------------------------
	// Edge flags
	// ----------------------------------------
	// Disabling or retuning can make a false edge; software clears it
	assign rise_evt = out_q & ~prev_q;
	assign fall_evt = ~out_q & prev_q;

	// Hardware set beats a same-cycle software clear
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rise_q <= 1'h0;
			fall_q <= 1'h0;
		end
		else
		begin
			rise_q <= rise_evt | (flag_wr ? rise_wdata : rise_q);
			fall_q <= fall_evt | (flag_wr ? fall_wdata : fall_q);
		end
	end

	assign stat = '{out_state: out_q, rise_flag: rise_q, fall_flag: fall_q};

endmodule // comp_channel
`default_nettype wire

// ===== rtl/dual_comparator_control_regs.sv
// APB register bank controlling two comparators
`timescale 1ns/1ps
`default_nettype none

// Contract
// - A comparator works only once software sets its enable bit 7; resets to 0.
// - Writing 0 to the enable bit shuts the comparator down.
// - Power-up or mode and hysteresis changes may set false edge flags.
// - Control bit 6 reads 1 when positive input exceeds negative input.
// - Rising flag, bit 5, sets on a rising edge and holds until written 0.
// - Falling flag, bit 4, sets on a falling edge and holds until written 0.
// - Bits 3:2 pick positive hysteresis: off, 5, 10 or 20 mV.
// - Bits 1:0 pick negative hysteresis: off, 5, 10 or 20 mV.
// - Mode bit 5 enables the rising-edge interrupt; resets to 0.
// - Mode bit 4 enables the falling-edge interrupt; resets to 0.
// - Mode bits 1:0 trade speed for power; reset value is 10.
// - Mode bit 7 reads 1; software always writes 1 there.
// - Mode bits 6 and 3:2 read 0 and ignore writes.
// - Comparator 0 control at 0x9B, mode at 0x9D, page 0x0.
// - Comparator 1 control at 0x9A with the same layout and behaviour.
// - A disabled comparator output and its state bit are held at 0.
// - Raw outputs are synchronised to the system clock before use.
// - Edge flags set whatever the interrupt enables are.
// - Interrupt only when flag, edge enable, source and global enables all set.
module dual_comparator_control_regs
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [comp_regs_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [comp_regs_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [comp_regs_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [comp_regs_pkg::NUM_COMP-1:0] comp_raw_out,
	input wire logic comp_irq_src_en,
	input wire logic global_irq_en,
	output comp_regs_pkg::comp_cfg_s comp_a_cfg,
	output comp_regs_pkg::comp_cfg_s comp_b_cfg,
	output comp_regs_pkg::speed_e comp_a_speed_mode,
	output logic comp_a_out_state,
	output logic comp_b_out_state,
	output logic comp_a_irq_req
);
	import comp_regs_pkg::*;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic reg_sel_e reg_decode(input logic [ADDR_W-1:0] addr);
		reg_sel_e sel;
		sel = SEL_NONE;
		case (addr)
			ADDR_COMP0_CONTROL: sel = SEL_C0_CTL;
			ADDR_COMP1_CONTROL: sel = SEL_C1_CTL;
			ADDR_COMP0_MODE: sel = SEL_C0_MODE;
			default: sel = SEL_NONE;
		endcase
		return sel;
	endfunction

	function automatic logic [7:0] ctl_word(input comp_cfg_s cfg, input comp_stat_s st);
		logic [7:0] w;
		w = 8'h00;
		w[CTL_EN_BIT] = cfg.enable;
		w[CTL_OUT_BIT] = st.out_state;
		w[CTL_RISE_BIT] = st.rise_flag;
		w[CTL_FALL_BIT] = st.fall_flag;
		w[CTL_PHYST_LSB +: 2] = cfg.pos_hyst;
		w[CTL_NHYST_LSB +: 2] = cfg.neg_hyst;
		return w;
	endfunction

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	comp_cfg_s cfg_q [NUM_COMP];
	comp_stat_s stat [NUM_COMP];
	logic [NUM_COMP-1:0] ctl_wr;
	logic rise_ie_q;
	logic fall_ie_q;
	speed_e speed_q;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic slverr_q;
	logic irq_q;
	logic wr_acc;
	logic mode_wr;
	reg_sel_e sel;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Zero wait states: data is fetched during setup, so access always finishes at once
	assign sel = reg_decode(paddr);
	assign pready = psel & penable;
	assign wr_acc = psel & penable & pwrite & pstrb[0];
	assign ctl_wr[0] = wr_acc & (sel == SEL_C0_CTL);
	assign ctl_wr[1] = wr_acc & (sel == SEL_C1_CTL);
	assign mode_wr = wr_acc & (sel == SEL_C0_MODE);
	assign prdata = rdata_q;
	assign pslverr = slverr_q & psel & penable;

	always_comb
	begin
		rdata_d = '0;
		case (sel)
			SEL_C0_CTL: rdata_d[7:0] = ctl_word(cfg_q[0], stat[0]);
			SEL_C1_CTL: rdata_d[7:0] = ctl_word(cfg_q[1], stat[1]);
			SEL_C0_MODE:
			begin
				rdata_d[MD_RSVD_BIT] = MD_RSVD_VAL;
				rdata_d[MD_RISE_IE_BIT] = rise_ie_q;
				rdata_d[MD_FALL_IE_BIT] = fall_ie_q;
				rdata_d[MD_SPEED_LSB +: 2] = speed_q;
			end
			default: rdata_d = '0;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rdata_q <= '0;
			slverr_q <= 1'h0;
		end
		else if (psel && !penable)
		begin
			rdata_q <= pwrite ? '0 : rdata_d;
			slverr_q <= (sel == SEL_NONE);
		end
	end

	// ----------------------------------------
	// Control registers and channels
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_COMP; gi++)
		begin : g_comp
			// Status bit 6 is read only; bits 5:4 go to the channel flags
			always_ff @(posedge core_clk)
			begin
				if (srst)
				begin
					cfg_q[gi] <= '{enable: 1'h0, pos_hyst: HYST_OFF, neg_hyst: HYST_OFF};
				end
				else if (ctl_wr[gi])
				begin
					cfg_q[gi].enable <= pwdata[CTL_EN_BIT];
					cfg_q[gi].pos_hyst <= hyst_e'(pwdata[CTL_PHYST_LSB +: 2]);
					cfg_q[gi].neg_hyst <= hyst_e'(pwdata[CTL_NHYST_LSB +: 2]);
				end
			end

			comp_channel u_chan
			(
				.core_clk(core_clk),
				.srst(srst),
				.raw_out(comp_raw_out[gi]),
				.cfg(cfg_q[gi]),
				.flag_wr(ctl_wr[gi]),
				.rise_wdata(pwdata[CTL_RISE_BIT]),
				.fall_wdata(pwdata[CTL_FALL_BIT]),
				.stat(stat[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Mode register
	// ----------------------------------------
	// Bit 7 is a constant; whatever software writes there is dropped
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rise_ie_q <= 1'h0;
			fall_ie_q <= 1'h0;
			speed_q <= speed_e'(SPEED_RESET);
		end
		else if (mode_wr)
		begin
			rise_ie_q <= pwdata[MD_RISE_IE_BIT];
			fall_ie_q <= pwdata[MD_FALL_IE_BIT];
			speed_q <= speed_e'(pwdata[MD_SPEED_LSB +: 2]);
		end
	end

	// ----------------------------------------
	// Interrupt request
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			irq_q <= 1'h0;
		end
		else
		begin
			irq_q <= comp_irq_src_en & global_irq_en
				& ((stat[0].rise_flag & rise_ie_q) | (stat[0].fall_flag & fall_ie_q));
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign comp_a_cfg = cfg_q[0];
	assign comp_b_cfg = cfg_q[1];
	assign comp_a_speed_mode = speed_q;
	assign comp_a_out_state = stat[0].out_state;
	assign comp_b_out_state = stat[1].out_state;
	assign comp_a_irq_req = irq_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	AST_EN_HOLD: assert property (!ctl_wr[0] |=> $stable(cfg_q[0].enable))
		else $error("enable changed without a write");

	AST_EN_CLEAR: assert property (ctl_wr[1] && !pwdata[CTL_EN_BIT] |=> !cfg_q[1].enable)
		else $error("write of 0 did not disable comparator");

	AST_OUT_DISABLED: assert property (!cfg_q[0].enable |=> !comp_a_out_state)
		else $error("disabled comparator shows output high");

	AST_OUT_SYNC: assert property ((cfg_q[1].enable && comp_raw_out[1]) [*3] |=> comp_b_out_state)
		else $error("synchronised output did not follow raw input");

	AST_RISE_SET: assert property ($rose(comp_a_out_state) |=> stat[0].rise_flag)
		else $error("rising edge did not set flag");

	AST_FALL_SET: assert property ($fell(comp_b_out_state) |=> stat[1].fall_flag)
		else $error("falling edge did not set flag");

	AST_FLAG_STICKY: assert property (stat[0].rise_flag && !ctl_wr[0] |=> stat[0].rise_flag)
		else $error("rising flag dropped without a write");

	AST_SET_WINS: assert property (ctl_wr[0] && comp_a_out_state && !$past(comp_a_out_state)
		|=> stat[0].rise_flag)
		else $error("edge lost against same-cycle clear");

	AST_HYST_WR: assert property (ctl_wr[0] |=> cfg_q[0].pos_hyst == $past(pwdata[3:2])
		&& cfg_q[0].neg_hyst == $past(pwdata[1:0]))
		else $error("hysteresis field not stored");

	AST_MODE_FIXED: assert property (psel && penable && !pwrite && sel == SEL_C0_MODE
		|-> prdata[7] && !prdata[6] && prdata[3:2] == 2'h0)
		else $error("mode constant bits read wrong");

	AST_IRQ_GATE: assert property (comp_a_irq_req |-> $past(comp_irq_src_en && global_irq_en))
		else $error("interrupt raised while source or global disabled");

	AST_IRQ_RAISE: assert property (comp_irq_src_en && global_irq_en && stat[0].fall_flag && fall_ie_q
		|=> comp_a_irq_req)
		else $error("enabled falling flag gave no interrupt");

	AST_SPEED_WR: assert property (mode_wr ##1 !mode_wr |-> speed_q == $past(pwdata[1:0], 2))
		else $error("speed mode not stored");

	// ----------------------------------------
	// Further channel checks
	// ----------------------------------------
	AST_EN_SET: assert property (ctl_wr[0] && pwdata[CTL_EN_BIT] |=> cfg_q[0].enable)
		else $error("write of 1 did not enable comparator");

	AST_B_EN_HOLD: assert property (!ctl_wr[1] |=> $stable(cfg_q[1]))
		else $error("comparator 1 settings changed without a write");

	AST_B_HYST_WR: assert property (ctl_wr[1] |=> cfg_q[1].pos_hyst == $past(pwdata[3:2])
		&& cfg_q[1].neg_hyst == $past(pwdata[1:0]))
		else $error("comparator 1 hysteresis not stored");

	AST_B_OUT_DISABLED: assert property (!cfg_q[1].enable |=> !comp_b_out_state)
		else $error("disabled comparator 1 shows output high");

	AST_A_OUT_SYNC: assert property ((cfg_q[0].enable && comp_raw_out[0]) [*3] |=> comp_a_out_state)
		else $error("comparator 0 output did not follow raw input");

	AST_A_OUT_LOW: assert property ((!comp_raw_out[0]) [*3] |=> !comp_a_out_state)
		else $error("comparator 0 output high with raw input low");

	AST_FALL_A_SET: assert property ($fell(comp_a_out_state) |=> stat[0].fall_flag)
		else $error("falling edge did not set comparator 0 flag");

	AST_RISE_B_SET: assert property ($rose(comp_b_out_state) |=> stat[1].rise_flag)
		else $error("rising edge did not set comparator 1 flag");

	AST_RISE_NO_IE: assert property ($rose(comp_a_out_state) && !rise_ie_q |=> stat[0].rise_flag)
		else $error("masked rising edge left flag clear");

	AST_FALL_STICKY: assert property (stat[0].fall_flag && !ctl_wr[0] |=> stat[0].fall_flag)
		else $error("falling flag dropped without a write");

	AST_FALL_CLEAR: assert property (ctl_wr[0] && !pwdata[CTL_FALL_BIT] && !$fell(comp_a_out_state)
		|=> !stat[0].fall_flag)
		else $error("write of 0 left falling flag set");

	AST_RISE_QUIET: assert property (!stat[0].rise_flag && !ctl_wr[0] && !$rose(comp_a_out_state)
		|=> !stat[0].rise_flag)
		else $error("rising flag set without an edge");

	// ----------------------------------------
	// Further mode and interrupt checks
	// ----------------------------------------
	AST_IE_WR: assert property (mode_wr |=> rise_ie_q == $past(pwdata[MD_RISE_IE_BIT])
		&& fall_ie_q == $past(pwdata[MD_FALL_IE_BIT]))
		else $error("edge interrupt enables not stored");

	AST_MODE_HOLD: assert property (!mode_wr
		|=> $stable(speed_q) && $stable(rise_ie_q) && $stable(fall_ie_q))
		else $error("mode register changed without a write");

	AST_IRQ_RISE: assert property (comp_irq_src_en && global_irq_en && stat[0].rise_flag && rise_ie_q
		|=> comp_a_irq_req)
		else $error("enabled rising flag gave no interrupt");

	AST_IRQ_MASKED: assert property (!rise_ie_q && !fall_ie_q |=> !comp_a_irq_req)
		else $error("interrupt raised with both edge enables off");

	AST_IRQ_NO_FLAG: assert property (!stat[0].rise_flag && !stat[0].fall_flag |=> !comp_a_irq_req)
		else $error("interrupt raised with no flag set");

	// ----------------------------------------
	// Further bus checks
	// ----------------------------------------
	AST_UNMAPPED_ERR: assert property (psel && penable && sel == SEL_NONE |-> pslverr)
		else $error("unmapped access gave no error");

	AST_MAPPED_OK: assert property (psel && penable && sel != SEL_NONE |-> !pslverr)
		else $error("mapped access gave an error");

	AST_B_CTL_READ: assert property (psel && penable && !pwrite && sel == SEL_C1_CTL
		|-> prdata[CTL_EN_BIT] == cfg_q[1].enable && prdata[CTL_NHYST_LSB +: 2] == cfg_q[1].neg_hyst)
		else $error("comparator 1 control read wrong");

	AST_RDATA_HIGH: assert property (psel && penable |-> prdata[DATA_W-1:8] == '0)
		else $error("unused read data bits set");

endmodule // dual_comparator_control_regs
`default_nettype wire

// ===== test/comp_core_model.sv
// Stand-in for one analog comparator core feeding a raw output
`timescale 1ns/1ps
`default_nettype none
module comp_core_model
(
	input wire logic core_clk,
	input wire logic enable,
	input wire logic pos_above,
	input wire logic slow,
	output logic raw_out
);
	logic late_q;
	// ----------------------------------------
	// Analog response
	// ----------------------------------------
	// Slow setting lags a cycle, like a low-power response mode
	always_ff @(posedge core_clk)
	begin
		late_q <= pos_above;
	end
	// Shut-down core output is junk; the bank must mask it itself
	assign raw_out = (enable & slow) ? late_q : pos_above;
endmodule // comp_core_model
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the dual comparator register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import comp_regs_pkg::*;
	logic core_clk, srst, psel, penable, pwrite, pready, pslverr, src_en, glb_en, irq, a_out, b_out, err;
	logic [ADDR_W-1:0] paddr, ca;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	wire logic [1:0] raw;
	logic [1:0] above, slow;
	logic [7:0] d;
	comp_cfg_s a_cfg, b_cfg;
	speed_e a_speed;
	int miscompares, check_count, cycles, c;

	dual_comparator_control_regs DUT (.core_clk(core_clk), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .comp_raw_out(raw), .comp_irq_src_en(src_en), .global_irq_en(glb_en),
		.comp_a_cfg(a_cfg), .comp_b_cfg(b_cfg), .comp_a_speed_mode(a_speed), .comp_a_out_state(a_out),
		.comp_b_out_state(b_out), .comp_a_irq_req(irq));
	comp_core_model core_a (.core_clk(core_clk), .enable(a_cfg.enable), .pos_above(above[0]), .slow(slow[0]),
		.raw_out(raw[0]));
	comp_core_model core_b (.core_clk(core_clk), .enable(b_cfg.enable), .pos_above(above[1]), .slow(slow[1]),
		.raw_out(raw[1]));

	// ----------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Whole run needs a few hundred cycles
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			results();
		end
	end
	task automatic results();
		if (miscompares == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic logic [7:0] exp_mode(input logic [7:0] v);
		return {2'b10, v[5:4], 2'b00, v[1:0]};
	endfunction
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [3:0] s);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= v;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		apb(1'b1, a, {24'h0, v}, 4'hF);
	endtask
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0, 4'hF);
		chk($sformatf("reg_%h", a), rd, {24'h0, e});
		chk("err", 32'(err), 32'h0);
	endtask
	// Covers sync, edge and registered request latency, plus slow core lag
	task automatic settle();
		repeat (8) @(posedge core_clk);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{above, slow, src_en, glb_en} = '0;
		srst = 1'b1;
		void'($urandom(32'h727ddc30));
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		rdc(ADDR_COMP0_CONTROL, 8'h00);
		rdc(ADDR_COMP1_CONTROL, 8'h00);
		rdc(ADDR_COMP0_MODE, 8'h82);
		apb(1'b0, 12'h270, 32'h0, 4'hF);
		chk("unmapped_err", err, 32'h1);
		chk("unmapped_data", rd, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			d = 8'($urandom);
			if (i < 4)
				d[1:0] = i[1:0];
			wr(ADDR_COMP0_MODE, d | 8'h80);
			rdc(ADDR_COMP0_MODE, exp_mode(d));
			chk("speed", 32'(a_speed), 32'(d[1:0]));
		end
		// Lane 0 strobe off leaves the mode untouched
		apb(1'b1, ADDR_COMP0_MODE, 32'hB1, 4'hE);
		rdc(ADDR_COMP0_MODE, exp_mode(d));
		for (int i = 0; i < 16; i++)
		begin
			wr(ADDR_COMP0_CONTROL, 8'(i));
			wr(ADDR_COMP1_CONTROL, 8'(15 - i));
			// Last write landed on the edge that ended its access; wait one more edge so it has settled before looking
			@(posedge core_clk);
			chk("a_cfg", 32'(a_cfg), 32'(i));
			chk("b_cfg", 32'(b_cfg), 32'(15 - i));
		end
		for (c = 0; c < 2; c++)
		begin
			ca = c ? ADDR_COMP1_CONTROL : ADDR_COMP0_CONTROL;
			slow[c] <= c[0];
			above[c] <= 1'b1;
			wr(ca, 8'h80);
			settle();
			chk("out", 32'(c ? b_out : a_out), 32'h1);
			rdc(ca, 8'hE0);
			wr(ca, 8'h80);
			rdc(ca, 8'hC0);
			above[c] <= 1'b0;
			settle();
			rdc(ca, 8'h90);
			wr(ca, 8'h00);
			above[c] <= 1'b1;
			settle();
			chk("off", 32'(c ? b_out : a_out), 32'h0);
			rdc(ca, 8'h00);
			above[c] <= 1'b0;
		end
		wr(ADDR_COMP0_MODE, 8'h90);
		wr(ADDR_COMP0_CONTROL, 8'h80);
		{src_en, glb_en} <= 2'b11;
		above[0] <= 1'b1;
		settle();
		chk("irq_rise_masked", 32'(irq), 32'h0);
		above[0] <= 1'b0;
		settle();
		chk("irq_fall", 32'(irq), 32'h1);
		glb_en <= 1'b0;
		settle();
		chk("irq_glb_off", 32'(irq), 32'h0);
		{src_en, glb_en} <= 2'b01;
		settle();
		chk("irq_src_off", 32'(irq), 32'h0);
		src_en <= 1'b1;
		wr(ADDR_COMP0_MODE, 8'hA0);
		wr(ADDR_COMP0_CONTROL, 8'h80);
		settle();
		chk("irq_cleared", 32'(irq), 32'h0);
		above[0] <= 1'b1;
		settle();
		chk("irq_rise", 32'(irq), 32'h1);
		// Clear lands on the very edge the rising flag sets
		above[0] <= 1'b0;
		settle();
		wr(ADDR_COMP0_CONTROL, 8'h80);
		above[0] <= 1'b1;
		@(posedge core_clk);
		wr(ADDR_COMP0_CONTROL, 8'h80);
		rdc(ADDR_COMP0_CONTROL, 8'hE0);
		results();
	end
endmodule // testbench
`default_nettype wire
